//--- src/stack_cache_pkg.sv
`default_nettype none
package stack_cache_pkg;
    localparam int WORD_W = 32;
    localparam int LOC_W = 7;
    localparam int LOC_DEPTH = 128;
    localparam int REG_NUM_W = 8;
    localparam int VEC_W = 8;
    localparam int SP_IDX_HI = 8;
    localparam int SP_IDX_LO = 2;
    localparam logic [REG_NUM_W-1:0] SP_GLOBAL_NUM = 8'h01;
    localparam logic [WORD_W-1:0] SP_RESET = 32'h0000_0000;
    localparam int OPS = 3;
    localparam int OP_C = 0;
    localparam int OP_A = 1;
    localparam int OP_B = 2;

    typedef enum logic [1:0] {
        ASSERT_NONE,
        ASSERT_GE_UNSIGNED,
        ASSERT_LE_UNSIGNED,
        ASSERT_EQUAL
    } assert_kind_t;
endpackage : stack_cache_pkg
`default_nettype wire

//--- src/local_index_adder.sv
`default_nettype none
module local_index_adder
    import stack_cache_pkg::*;
(
    // Operand offset and pointer word index
    input wire logic [LOC_W-1:0] offset,
    input wire logic [LOC_W-1:0] sp_index,
    // Absolute local register number
    output logic [LOC_W-1:0] abs_num
);
    logic [LOC_W:0] sum;

    always_comb begin
        sum = {1'b0, offset} + {1'b0, sp_index};
        abs_num = sum[LOC_W-1:0];
    end
endmodule : local_index_adder
`default_nettype wire

//--- src/assert_compare.sv
`default_nettype none
module assert_compare
    import stack_cache_pkg::*;
(
    // Assert request
    input wire assert_kind_t kind,
    input wire logic [WORD_W-1:0] op_a,
    input wire logic [WORD_W-1:0] op_b,
    input wire logic same_reg,
    // Trap decision
    output logic trap
);
    always_comb begin
        case (kind)
            ASSERT_GE_UNSIGNED: trap = op_a < op_b;
            ASSERT_LE_UNSIGNED: trap = op_a > op_b;
            // Same register cannot differ, so this is the pipeline filler
            ASSERT_EQUAL: trap = !same_reg && (op_a != op_b);
            default: trap = 1'b0;
        endcase
    end
endmodule : assert_compare
`default_nettype wire

//--- src/stack_cache_regs.sv
`default_nettype none
module stack_cache_regs
    import stack_cache_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Operand fields: bit 7 set selects a local register
    input wire logic [REG_NUM_W-1:0] num_a,
    input wire logic [REG_NUM_W-1:0] num_b,
    input wire logic [REG_NUM_W-1:0] num_c,
    // Writeback to operand C
    input wire logic wr_en,
    input wire logic [WORD_W-1:0] wr_data,
    // Assert instruction
    input wire logic assert_valid,
    input wire assert_kind_t assert_kind,
    input wire logic [VEC_W-1:0] assert_vector,
    // Read data
    output logic [WORD_W-1:0] rd_a,
    output logic [WORD_W-1:0] rd_b,
    // Absolute local numbers formed from current pointer
    output logic [LOC_W-1:0] abs_a,
    output logic [LOC_W-1:0] abs_b,
    output logic [LOC_W-1:0] abs_c,
    // Pointer view and trap
    output logic [WORD_W-1:0] stack_pointer_global,
    output logic trap_valid,
    output logic [VEC_W-1:0] trap_vector
);
    typedef struct packed {
        logic [WORD_W-1:0] sp;
        logic trap;
        logic [VEC_W-1:0] vec;
    } state_t;

    state_t state_q;
    state_t state_d;
    // Local file holds only data; nothing marks residency, by design
    logic [WORD_W-1:0] local_mem [LOC_DEPTH];
    logic [LOC_W-1:0] offs [OPS];
    logic [LOC_W-1:0] absn [OPS];
    logic [LOC_W-1:0] sp_index;
    logic do_trap;

    // Word index is address bits 8-2, so addresses 512 apart alias
    assign sp_index = state_q.sp[SP_IDX_HI:SP_IDX_LO];
    assign offs[OP_C] = num_c[LOC_W-1:0];
    assign offs[OP_A] = num_a[LOC_W-1:0];
    assign offs[OP_B] = num_b[LOC_W-1:0];

    genvar g;
    generate
        for (g = 0; g < OPS; g++) begin : g_add
            local_index_adder u_add (
                .offset(offs[g]),
                .sp_index(sp_index),
                .abs_num(absn[g])
            );
        end
    endgenerate

    assign abs_c = absn[OP_C];
    assign abs_a = absn[OP_A];
    assign abs_b = absn[OP_B];

    function automatic logic [WORD_W-1:0] read_op(input logic [REG_NUM_W-1:0] n,
                                                  input logic [LOC_W-1:0] a,
                                                  input logic [WORD_W-1:0] sp);
        if (n[REG_NUM_W-1])
            return local_mem[a];
        else if (n == SP_GLOBAL_NUM)
            return sp;
        else
            return '0;
    endfunction : read_op

    assign rd_a = read_op(num_a, absn[OP_A], state_q.sp);
    assign rd_b = read_op(num_b, absn[OP_B], state_q.sp);

    assert_compare u_cmp (
        .kind(assert_valid ? assert_kind : ASSERT_NONE),
        .op_a(rd_a),
        .op_b(rd_b),
        .same_reg(num_a == num_b),
        .trap(do_trap)
    );

    always_comb begin
        state_d = state_q;
        state_d.trap = do_trap;
        state_d.vec = do_trap ? assert_vector : state_q.vec;
        // No interlock: a write here affects operands only from next cycle
        if (wr_en && num_c == SP_GLOBAL_NUM)
            state_d.sp = wr_data;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{sp: SP_RESET, trap: 1'b0, vec: '0};
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_en && num_c[REG_NUM_W-1])
            local_mem[absn[OP_C]] <= wr_data;
    end

    assign stack_pointer_global = state_q.sp;
    assign trap_valid = state_q.trap;
    assign trap_vector = state_q.vec;
endmodule : stack_cache_regs
`default_nettype wire

//--- test/stack_cache_properties.sv
`default_nettype none
module stack_cache_properties import stack_cache_pkg::*; (
    input wire logic clk_sys, rst_b, wr_en, assert_valid, trap_valid,
    input wire logic [7:0] num_a, num_b, num_c, assert_vector, trap_vector,
    input wire logic [31:0] wr_data, rd_a, rd_b, stack_pointer_global,
    input wire logic [6:0] abs_a, abs_b, abs_c,
    input wire assert_kind_t assert_kind
);
    timeunit 1ns / 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic [6:0] idx = stack_pointer_global[8:2];
    AST_ABS_A: assert property (abs_a == num_a[6:0] + idx) else $error("abs a");
    AST_ABS_B: assert property (abs_b == num_b[6:0] + idx) else $error("abs b");
    AST_ABS_C: assert property (abs_c == num_c[6:0] + idx) else $error("abs c");
    AST_SP_WR: assert property (wr_en && num_c == 8'h01
        |=> stack_pointer_global == $past(wr_data)) else $error("sp");
    AST_GE: assert property (assert_valid && assert_kind == ASSERT_GE_UNSIGNED
        |=> trap_valid == ($past(rd_a) < $past(rd_b))) else $error("ge");
    AST_LE: assert property (assert_valid && assert_kind == ASSERT_LE_UNSIGNED
        |=> trap_valid == ($past(rd_a) > $past(rd_b))) else $error("le");
    AST_EQ: assert property (assert_valid && assert_kind == ASSERT_EQUAL && num_a == num_b
        |=> !trap_valid) else $error("eq");
    AST_QUIET: assert property (!assert_valid |=> !trap_valid) else $error("quiet");
    AST_VEC: assert property (trap_valid |-> trap_vector == $past(assert_vector))
        else $error("vec");
endmodule : stack_cache_properties
bind stack_cache_regs stack_cache_properties chk (.*);
`default_nettype wire

//--- test/pipe_model.sv
`default_nettype none
module pipe_model import stack_cache_pkg::*; (
    input wire logic clk_sys,
    output logic [7:0] num_a, num_b, num_c, assert_vector,
    output logic [31:0] wr_data,
    output logic wr_en, assert_valid,
    output assert_kind_t assert_kind
);
    timeunit 1ns / 1ns;
    initial {num_a, num_b, num_c, assert_vector, wr_data, wr_en, assert_valid} = '0;
    initial assert_kind = ASSERT_NONE;
    // A bubble after each issue: the pipeline has no pointer interlock
    task automatic issue(input logic [23:0] n, input logic w, input logic [31:0] d,
        input assert_kind_t k = ASSERT_NONE, input logic [7:0] v = 0);
        @(negedge clk_sys);
        {num_a, num_b, num_c, wr_en, wr_data, assert_vector} = {n, w, d, v};
        assert_kind = k;
        assert_valid = k != ASSERT_NONE;
        @(negedge clk_sys);
        {wr_en, assert_valid} = 2'b00;
    endtask : issue
endmodule : pipe_model
`default_nettype wire

//--- test/tb_top.sv
`default_nettype none
module tb_top import stack_cache_pkg::*;;
    timeunit 1ns / 1ns;
    logic clk_sys = 0, rst_b = 0, pend = 0, wr_en, assert_valid, trap_valid, t;
    logic [7:0] num_a, num_b, num_c, assert_vector, trap_vector, v, last_v = 0;
    logic [31:0] wr_data, rd_a, rd_b, stack_pointer_global, s, x, y;
    logic [6:0] abs_a, abs_b, abs_c, o, m;
    assert_kind_t assert_kind;
    logic [8:0] q[$];
    int err_total = 0, cmp_count = 0, seed = 13;
    pipe_model pm (.*);
    stack_cache_regs dut (.*);
    initial forever #10 clk_sys = ~clk_sys;
    // Run needs about 5 us, so twenty times that means a hang
    initial #100000 report_and_stop(1);
    task automatic report_and_stop(input int e);
        err_total += e;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    always @(posedge clk_sys) pend <= assert_valid;
    always @(negedge clk_sys) begin
        if (pend) chk("trap", 32'(q.pop_front()), 32'({trap_valid, trap_vector}));
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_b = 1;
        chk("sp", 0, stack_pointer_global);
        for (int i = 0; i < 12; i++) begin
            {s, x, o, m} = {$random(seed), $random(seed), 14'($random(seed))};
            y = i[0] ? x : ~x;
            v = 8'(i + 64);
            pm.issue(24'h1, 1, s);
            pm.issue({17'h1, o}, 1, x);
            pm.issue(24'h1, 1, s + 512 * i - 4 * m);
            pm.issue({1'b1, 7'(o + m), 16'h0}, 0, 0);
            chk("rd_a", x, rd_a);
            pm.issue(24'h010000, 0, 0);
            chk("rd_sp", s + 512 * i - 4 * m, rd_a);
            pm.issue(24'h80, 1, x);
            pm.issue(24'h81, 1, y);
            for (int k = 1; k < 5; k++) begin
                t = k == 1 ? x < y : k == 2 ? x > y : k == 4 && x != y;
                q.push_back({t, t ? v : last_v});
                last_v = t ? v : last_v;
                pm.issue(k == 3 ? 24'h808000 : 24'h808100, 0, 0,
                    assert_kind_t'(k == 4 ? 3 : k), v);
            end
        end
        @(negedge clk_sys);
        report_and_stop(0);
    end
endmodule : tb_top
`default_nettype wire
